// [hdl/cbrc_top.sv]
`timescale 1ns/100ps
`default_nettype none
module cbrc_top
    import cbrc_pkg::*;
(
    input wire logic clk_sys,                 // CPU clock
    input wire logic rst,                     // Master power-on reset
    input wire logic user_rst_n,              // User reset
    input wire logic bus_req,                 // External master request
    input wire logic wait_req,                // Stall request
    input wire logic int_req,                 // Maskable interrupt pending
    input wire logic nmi_req,                 // Non-maskable interrupt
    input wire logic [1:0] chan_transfer_request, // Channel requests
    input wire logic [1:0] chan_edge_mode,    // Per channel edge select
    input wire logic chan_dma_write,          // Channel cycle writes
    input wire logic [15:0] chan_dma_addr,    // Channel address
    input wire logic [7:0] chan_dma_wdata,    // Channel write data
    input wire logic lookahead_en,            // Lookahead enable
    input wire cbrc_kind_e core_kind,         // Core request this cycle
    input wire logic [15:0] core_addr,        // Core address
    input wire logic [7:0] core_wdata,        // Core write data
    input wire logic core_reti,               // Return from interrupt
    input wire logic core_instr_end,          // Last machine cycle
    input wire logic core_addr_calc,          // Address calculation
    input wire logic [15:0] core_next_pc,     // Next opcode address
    input wire logic core_halt_exec,          // Halt executed
    input wire logic core_sleep_exec,         // Sleep executed
    input wire logic [7:0] mem_data_in,       // Memory read data
    output logic bus_grant,                   // Bus released
    output logic halt_status,                 // Halted
    output logic doze_status,                 // Dozing
    output logic iack_tran,                   // Interrupt acknowledge
    output logic nmiack_tran,                 // NMI acknowledge
    output logic reti_tran,                   // Return from interrupt
    output logic first_cycle_marker,          // First clock of cycle
    output logic mem_tran,                    // Memory transaction
    output logic mem_rd,                      // Memory read strobe
    output logic mem_wr,                      // Memory write strobe
    output logic io_tran,                     // Port transaction
    output logic io_strobe,                   // Port strobe
    output logic io_read,                     // Port direction
    output logic ivec_rd,                     // Vector read strobe
    output logic [15:0] mem_addr_out,         // Memory address
    output logic [7:0] mem_data_out,          // Memory write data
    output logic [15:0] io_addr_out,          // Port address
    output logic [7:0] io_data_out,           // Port write data
    output logic core_step,                   // Machine cycle done
    output logic pf_hit,                      // Prefix served early
    output logic [7:0] pf_byte,               // Last prefetched byte
    output logic [1:0] chan_ack               // Channel cycle started
);
    typedef struct packed {
        logic phase;
        cbrc_state_e st;
        cbrc_own_e own;
        logic chan;
        cbrc_kind_e kind;
        logic pf_cyc;
        logic pf_valid;
        logic grant;
        logic iack;
        logic nmiack;
        logic reti;
        logic first;
        logic mtran;
        logic mrd;
        logic mwr;
        logic itran;
        logic istb;
        logic ird;
        logic vrd;
        logic [15:0] maddr;
        logic [7:0] mdata;
        logic [15:0] iaddr;
        logic [7:0] idata;
        logic step;
        logic hit;
        logic [1:0] cack;
    } cbrc_core_s;

    // Lookahead store, cleared only by the master reset
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
    } cbrc_pf_s;

    localparam cbrc_core_s CBRC_CORE_RST = '{
        phase: 1'b0, st: CS_RUN, own: OWN_CPU, chan: 1'b0, kind: K_IDLE,
        pf_cyc: 1'b0, pf_valid: 1'b0, grant: 1'b0, iack: 1'b0,
        nmiack: 1'b0, reti: 1'b0, first: 1'b0, mtran: 1'b0, mrd: 1'b0,
        mwr: 1'b0, itran: 1'b0, istb: 1'b0, ird: 1'b0, vrd: 1'b0,
        maddr: CBRC_ADDR_RST, mdata: CBRC_DATA_RST, iaddr: CBRC_ADDR_RST,
        idata: CBRC_DATA_RST, step: 1'b0, hit: 1'b0, cack: 2'h0};

    cbrc_core_s q;
    cbrc_core_s d;
    cbrc_pf_s pq;
    cbrc_pf_s pd;
    logic [1:0] chan_pend;

    genvar gi;
    generate
        for (gi = 0; gi < CBRC_NCHAN; gi++)
        begin : g_chan
            cbrc_chan_req u_chan (
                .clk_sys(clk_sys),
                .rst(rst),
                .user_rst_n(user_rst_n),
                .req(chan_transfer_request[gi]),
                .edge_mode(chan_edge_mode[gi]),
                .take(q.cack[gi]),
                .pending(chan_pend[gi])
            );
        end
    endgenerate

    function automatic logic is_prefix(input logic [7:0] b);
        is_prefix = (b == CBRC_PFX_BIT) || (b == CBRC_PFX_IX) ||
            (b == CBRC_PFX_EXT) || (b == CBRC_PFX_IY);
    endfunction

    always_comb
    begin
        logic stall;
        logic cyc_end;
        logic boundary;
        logic start;
        cbrc_kind_e k;
        logic [15:0] a;
        logic [7:0] w;
        stall = 1'b0;
        cyc_end = 1'b0;
        boundary = 1'b0;
        start = 1'b0;
        k = K_IDLE;
        a = core_addr;
        w = core_wdata;
        d = q;
        pd = pq;
        d.step = 1'b0;
        d.hit = 1'b0;
        d.cack = 2'h0;
        d.first = 1'b0;
        d.mrd = 1'b0;
        d.mwr = 1'b0;
        d.istb = 1'b0;
        d.vrd = 1'b0;
        if (!lookahead_en)
        begin
            d.pf_valid = 1'b0;
        end
        stall = wait_req & ~q.grant & (q.st == CS_RUN);
        if (q.grant)
        begin
            if (!bus_req)
            begin
                d.grant = 1'b0;
                d.phase = 1'b0;
                start = (q.st == CS_RUN);
            end
        end
        else if (!q.phase)
        begin
            d.phase = 1'b1;
            d.mrd = q.kind == K_MEM_RD || q.kind == K_FETCH;
            d.mwr = q.kind == K_MEM_WR;
            d.istb = q.kind == K_IO_RD || q.kind == K_IO_WR;
            d.vrd = q.kind == K_IACK;
        end
        else if (!stall)
        begin
            cyc_end = 1'b1;
            d.phase = 1'b0;
        end
        if (cyc_end)
        begin
            case (q.st)
                CS_RUN:
                begin
                    if (q.own == OWN_CPU)
                    begin
                        d.step = 1'b1;
                        boundary = core_instr_end;
                        if (q.pf_cyc)
                        begin
                            d.pf_valid = lookahead_en;
                            pd.data = mem_data_in;
                        end
                        if (core_halt_exec)
                        begin
                            d.st = CS_HALT;
                        end
                        else if (core_sleep_exec)
                        begin
                            d.st = CS_DOZE;
                        end
                    end
                    else
                    begin
                        boundary = 1'b1;
                    end
                end
                default:
                begin
                    if (int_req || nmi_req)
                    begin
                        d.st = CS_RUN;
                    end
                    boundary = 1'b1;
                end
            endcase
            d.own = OWN_CPU;
            if (boundary && bus_req)
            begin
                d.grant = 1'b1;
            end
            else if (boundary && d.st == CS_RUN && chan_pend != 2'h0)
            begin
                d.own = OWN_DMA;
                d.chan = ~chan_pend[0];
                d.cack = chan_pend[0] ? 2'h1 : 2'h2;
                start = 1'b1;
            end
            else
            begin
                start = d.st == CS_RUN;
            end
        end
        if (start)
        begin
            d.pf_cyc = 1'b0;
            if (d.own == OWN_DMA)
            begin
                k = chan_dma_write ? K_MEM_WR : K_MEM_RD;
                a = chan_dma_addr;
                w = chan_dma_wdata;
            end
            else
            begin
                k = core_kind;
                if (k == K_FETCH)
                begin
                    if (q.pf_valid && core_addr == pq.addr &&
                        is_prefix(pq.data))
                    begin
                        k = K_IDLE;
                        d.hit = 1'b1;
                    end
                    d.pf_valid = 1'b0;
                end
                else if (k == K_IDLE && core_addr_calc && lookahead_en)
                begin
                    k = K_MEM_RD;
                    a = core_next_pc;
                    d.pf_cyc = 1'b1;
                    d.pf_valid = 1'b0;
                    pd.addr = core_next_pc;
                end
            end
            d.kind = k;
            d.first = k != K_IDLE;
            d.mtran = k == K_MEM_RD || k == K_MEM_WR || k == K_FETCH;
            d.itran = k == K_IO_RD || k == K_IO_WR;
            d.ird = k == K_IO_RD;
            d.iack = k == K_IACK;
            d.nmiack = k == K_NMIACK;
            d.reti = core_reti && d.own == OWN_CPU;
            if (d.mtran)
            begin
                d.maddr = a;
                d.mdata = w;
            end
            if (d.itran)
            begin
                d.iaddr = a;
                d.idata = w;
            end
        end
        else if (cyc_end || d.grant)
        begin
            d.kind = K_IDLE;
        end
        if (d.grant || d.st != CS_RUN)
        begin
            d.kind = K_IDLE;
            d.pf_cyc = 1'b0;
            d.iack = 1'b0;
            d.nmiack = 1'b0;
            d.reti = 1'b0;
            d.first = 1'b0;
            d.mtran = 1'b0;
            d.mrd = 1'b0;
            d.mwr = 1'b0;
            d.itran = 1'b0;
            d.istb = 1'b0;
            d.ird = 1'b0;
            d.vrd = 1'b0;
            d.maddr = CBRC_ADDR_RST;
            d.mdata = CBRC_DATA_RST;
            d.iaddr = CBRC_ADDR_RST;
            d.idata = CBRC_DATA_RST;
        end
    end

    always_ff @(posedge clk_sys or posedge rst or negedge user_rst_n)
    begin
        if (rst)
        begin
            q <= CBRC_CORE_RST;
        end
        else if (!user_rst_n)
        begin
            q <= CBRC_CORE_RST;
        end
        else
        begin
            q <= d;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pq <= '{addr: CBRC_ADDR_RST, data: CBRC_DATA_RST};
        end
        else
        begin
            pq <= pd;
        end
    end

    assign bus_grant = q.grant;
    assign halt_status = q.st == CS_HALT;
    assign doze_status = q.st == CS_DOZE;
    assign iack_tran = q.iack;
    assign nmiack_tran = q.nmiack;
    assign reti_tran = q.reti;
    assign first_cycle_marker = q.first;
    assign mem_tran = q.mtran;
    assign mem_rd = q.mrd;
    assign mem_wr = q.mwr;
    assign io_tran = q.itran;
    assign io_strobe = q.istb;
    assign io_read = q.ird;
    assign ivec_rd = q.vrd;
    assign mem_addr_out = q.maddr;
    assign mem_data_out = q.mdata;
    assign io_addr_out = q.iaddr;
    assign io_data_out = q.idata;
    assign core_step = q.step;
    assign pf_hit = q.hit;
    assign pf_byte = pq.data;
    assign chan_ack = q.cack;
endmodule
`default_nettype wire

// [hdl/cbrc_pkg.sv]
// Function
// - Inputs sampled, outputs change on rising edge
// - Every machine cycle is two clocks, extended while stall request held
// - Yield bus only at instruction boundaries
// - External master beats internal DMA channels
// - Grant forces strobes and buses low
// - Halt or doze status held during grant
// - No interrupt sampling while bus granted
// - Channel requests edge or level sensitive
// - Lookahead fetches opcode during address calculation
// - Only prefix bytes used, others refetched
// - Halt asserts status, freezes, forces buses low
// - Master reset initialises remaining flip-flops
// - One CPU clock drives every flip-flop
// - Mark maskable interrupt acknowledge transactions
// - Separate memory and port buses, none tristated
// - User reset initialises state flip-flops
// - Stall request ignored during grant, halt, doze
// - Sleep asserts doze status until interrupt
package cbrc_pkg;

    localparam int CBRC_AW = 16;
    localparam int CBRC_DW = 8;
    localparam int CBRC_NCHAN = 2;
    // Clocks per machine cycle; the phase flag counts them
    localparam int CBRC_MCYC_CLKS = 2;

    localparam logic [7:0] CBRC_PFX_BIT = 8'hCB;
    localparam logic [7:0] CBRC_PFX_IX = 8'hDD;
    localparam logic [7:0] CBRC_PFX_EXT = 8'hED;
    localparam logic [7:0] CBRC_PFX_IY = 8'hFD;

    localparam logic [CBRC_AW-1:0] CBRC_ADDR_RST = 16'h0000;
    localparam logic [CBRC_DW-1:0] CBRC_DATA_RST = 8'h00;

    typedef enum logic [1:0] {
        CS_RUN,
        CS_HALT,
        CS_DOZE
    } cbrc_state_e;

    typedef enum logic [1:0] {
        OWN_CPU,
        OWN_DMA
    } cbrc_own_e;

    typedef enum logic [2:0] {
        K_IDLE,
        K_MEM_RD,
        K_MEM_WR,
        K_IO_RD,
        K_IO_WR,
        K_IACK,
        K_NMIACK,
        K_FETCH
    } cbrc_kind_e;

endpackage

// [hdl/cbrc_chan_req.sv]
`timescale 1ns/100ps
`default_nettype none
module cbrc_chan_req
    import cbrc_pkg::*;
(
    input wire logic clk_sys,      // CPU clock
    input wire logic rst,          // Master reset
    input wire logic user_rst_n,   // User reset
    input wire logic req,          // Channel transfer request
    input wire logic edge_mode,    // 1 edge, 0 level sensitive
    input wire logic take,         // Transfer started
    output logic pending           // Request awaiting service
);
    typedef struct packed {
        logic prev;
        logic pend;
    } cbrc_chan_s;

    cbrc_chan_s q;
    cbrc_chan_s d;

    always_comb
    begin
        d.prev = req;
        if (edge_mode)
        begin
            d.pend = (req & ~q.prev) | (q.pend & ~take);
        end
        else
        begin
            d.pend = req;
        end
    end

    always_ff @(posedge clk_sys or posedge rst or negedge user_rst_n)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else if (!user_rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign pending = q.pend;
endmodule
`default_nettype wire

// [verif/cbrc_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module cbrc_assertions
    import cbrc_pkg::*;
(
    input wire logic clk_sys, // CPU clock
    input wire logic rst, // Master reset
    input wire logic user_rst_n, // User reset
    input wire logic bus_req, // Master request
    input wire cbrc_kind_e core_kind, // Core request
    input wire logic bus_grant, // Bus released
    input wire logic halt_status, // Halted
    input wire logic doze_status, // Dozing
    input wire logic iack_tran, // Interrupt ack
    input wire logic nmiack_tran, // NMI ack
    input wire logic reti_tran, // Interrupt return
    input wire logic first_cycle_marker, // First clock
    input wire logic mem_tran, // Memory cycle
    input wire logic mem_rd, // Read strobe
    input wire logic mem_wr, // Write strobe
    input wire logic io_tran, // Port cycle
    input wire logic io_strobe, // Port strobe
    input wire logic ivec_rd, // Vector strobe
    input wire logic [15:0] io_addr_out // Port address
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst || !user_rst_n);

    AST_GRANT_QUIET:
        assert property (bus_grant |-> !(io_tran || iack_tran || nmiack_tran
            || reti_tran || ivec_rd) && io_addr_out == 16'h0000)
        else $error("bus outputs active during grant");
    AST_GRANT_CAUSE:
        assert property ($rose(bus_grant) |-> $past(bus_req))
        else $error("grant without request");
    AST_GRANT_DROP:
        assert property (bus_grant && !bus_req |=> !bus_grant)
        else $error("grant kept after request fell");
    AST_RESUME:
        assert property (bus_grant && !bus_req && !halt_status && !doze_status
            && core_kind != K_IDLE |=> first_cycle_marker)
        else $error("no cycle started after grant");
    AST_HALT_KEEP:
        assert property (halt_status && bus_grant |=> halt_status)
        else $error("halt left during grant");
    AST_DOZE_KEEP:
        assert property (doze_status && bus_grant |=> doze_status)
        else $error("doze left during grant");
    AST_HALT_QUIET:
        assert property (halt_status |-> !(first_cycle_marker || mem_tran
            || io_tran || iack_tran || reti_tran))
        else $error("bus activity while halted");
    AST_MEM_PHASE:
        assert property (first_cycle_marker && mem_tran |=> mem_tran
            && !first_cycle_marker && (mem_rd ^ mem_wr))
        else $error("memory strobe not in second clock");
    AST_IO_PHASE:
        assert property (first_cycle_marker && io_tran |=> io_strobe
            && io_tran && !mem_tran)
        else $error("port strobe not in second clock");
    AST_IACK_VEC:
        assert property (first_cycle_marker && iack_tran |=> ivec_rd)
        else $error("acknowledge cycle without vector strobe");
    AST_RST_QUIET:
        assert property (disable iff (1'b0)
            rst |-> !(bus_grant || halt_status || doze_status || mem_tran))
        else $error("outputs active in master reset");
endmodule
`default_nettype wire

// [verif/cbrc_ext_master.sv]
`timescale 1ns/100ps
`default_nettype none
module cbrc_ext_master
    import cbrc_pkg::*;
(
    input wire logic clk_sys, // CPU clock
    input wire logic rst, // Master reset
    input wire logic go, // Start one tenure
    input wire logic [3:0] hold, // Granted clocks to use, minus one
    input wire logic bus_grant, // Bus released
    output logic bus_req // Bus request
);
    logic [3:0] cnt_q;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            bus_req <= 1'h0;
            cnt_q <= 4'h0;
        end
        else if (go)
        begin
            bus_req <= 1'h1;
            cnt_q <= 4'h0;
        end
        else if (bus_req && bus_grant)
        begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == hold)
                bus_req <= 1'h0;
        end
    end
endmodule
`default_nettype wire

// [verif/cpu_bus_release_control_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_release_control_tb
    import cbrc_pkg::*;
;
    logic clk_sys, rst, user_rst_n, bus_req, wait_req, int_req, nmi_req;
    logic [1:0] chan_transfer_request, chan_edge_mode, chan_ack;
    logic chan_dma_write, lookahead_en, core_reti, core_instr_end;
    logic [15:0] chan_dma_addr, core_addr, core_next_pc;
    logic [7:0] chan_dma_wdata, core_wdata, mem_data_in;
    cbrc_kind_e core_kind;
    logic core_addr_calc, core_halt_exec, core_sleep_exec, em_go;
    logic bus_grant, halt_status, doze_status, iack_tran, nmiack_tran;
    logic reti_tran, first_cycle_marker, mem_tran, mem_rd, mem_wr;
    logic io_tran, io_strobe, io_read, ivec_rd, core_step, pf_hit;
    logic [15:0] mem_addr_out, io_addr_out;
    logic [7:0] mem_data_out, io_data_out, pf_byte;
    int errors, cmp_count;

    cbrc_top dut_u (.*);
    cbrc_ext_master em_u (.clk_sys(clk_sys), .rst(rst), .go(em_go),
        .hold(4'h4), .bus_grant(bus_grant), .bus_req(bus_req));

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string nm, input logic [63:0] seen,
        input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wait_hi(ref logic s);
        for (int n = 0; n < 12 && s !== 1'h1; n++)
        begin
            @(posedge clk_sys);
            #1;
        end
    endtask

    // Leaves the caller one clock before a cycle boundary
    task automatic wait_step();
        @(posedge clk_sys);
        #1;
        wait_hi(core_step);
        check("step", core_step, 1'h1);
        @(posedge clk_sys);
    endtask

    task automatic run_cycle(input cbrc_kind_e k, input logic [15:0] a);
        wait_step();
        core_kind <= k;
        core_addr <= a;
        core_wdata <= a[15:8];
        @(posedge clk_sys);
        core_kind <= K_IDLE;
    endtask

    task automatic t_cycles();
        cbrc_kind_e ks[6];
        logic [2:0] tr[6];
        logic [3:0] st[6];
        logic [15:0] a;
        ks = '{K_MEM_RD, K_MEM_WR, K_IO_RD, K_IO_WR, K_IACK, K_NMIACK};
        tr = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h1, 3'h0};
        st = '{4'h8, 4'h4, 4'h2, 4'h2, 4'h1, 4'h0};
        // vector data left to the read-data side
        for (int i = 0; i < 6; i++)
        begin
            a = 16'hA5C0 + 16'(i);
            run_cycle(ks[i], a);
            #1;
            check("first", first_cycle_marker, 1'h1);
            check("tran", {mem_tran, io_tran, iack_tran}, tr[i]);
            check("nmiack", nmiack_tran, i == 5);
            if (i < 4)
                check("addr", i < 2 ? mem_addr_out : io_addr_out, a);
            if (i == 2 || i == 3)
                check("dir", io_read, i == 2);
            @(posedge clk_sys);
            #1;
            check("strobe", {mem_rd, mem_wr, io_strobe, ivec_rd}, st[i]);
            if (i == 1 || i == 3)
                check("wdata", i == 1 ? mem_data_out : io_data_out, a[15:8]);
            @(posedge clk_sys);
            #1;
            check("end", core_step, 1'h1);
        end
    endtask

    task automatic t_look();
        logic [7:0] bytes[5];
        logic [1:0] seen;
        bytes = '{8'hCB, 8'hDD, 8'hED, 8'hFD, 8'h3E};
        for (int i = 0; i < 5; i++)
        begin
            wait_step();
            lookahead_en <= 1'h1;
            core_addr_calc <= 1'h1;
            core_next_pc <= 16'h4D21;
            mem_data_in <= bytes[i];
            @(posedge clk_sys);
            core_addr_calc <= 1'h0;
            @(posedge clk_sys);
            #1;
            check("look_rd", {mem_rd, mem_addr_out}, 17'h14D21);
            run_cycle(K_FETCH, 16'h4D21);
            seen = 2'h0;
            repeat (3)
            begin
                #1;
                seen |= {pf_hit, mem_rd};
                @(posedge clk_sys);
            end
            #1;
            check("look_byte", pf_byte, bytes[i]);
            check("look_use", seen, i < 4 ? 2'h2 : 2'h1);
        end
    endtask

    task automatic t_grant();
        logic [1:0] acks;
        wait_step();
        core_instr_end <= 1'h0;
        {chan_dma_write, chan_dma_addr, chan_dma_wdata} <= 25'h13C5A96;
        chan_edge_mode <= 2'h2;
        chan_transfer_request <= 2'h3;
        em_go <= 1'h1;
        @(posedge clk_sys);
        em_go <= 1'h0;
        chan_transfer_request <= 2'h1;
        repeat (6)
        begin
            @(posedge clk_sys);
            #1;
            check("grant_mid", {bus_grant, chan_ack}, 3'h0);
        end
        @(posedge clk_sys);
        core_instr_end <= 1'h1;
        core_kind <= K_MEM_RD;
        acks = 2'h0;
        for (int n = 0; n < 16 && bus_req === 1'h1; n++)
        begin
            @(posedge clk_sys);
            #1;
            acks |= chan_ack;
            if (bus_grant === 1'h1)
                check("quiet", {mem_tran, io_tran, first_cycle_marker,
                    mem_addr_out, io_addr_out}, 35'h0);
        end
        check("grant_hold", bus_grant, 1'h1);
        check("chan_defer", acks, 2'h0);
        @(posedge clk_sys);
        core_kind <= K_IDLE;
        #1;
        check("resume", {bus_grant, first_cycle_marker}, 2'h1);
        for (int n = 0; n < 12; n++)
        begin
            @(posedge clk_sys);
            if (acks[0])
                chan_transfer_request <= 2'h0;
            #1;
            acks |= chan_ack;
        end
        check("chan_served", acks, 2'h3);
    endtask

    task automatic t_park(input logic hlt);
        logic [1:0] st;
        st = hlt ? 2'h2 : 2'h1;
        wait_step();
        core_halt_exec <= hlt;
        core_sleep_exec <= !hlt;
        @(posedge clk_sys);
        {core_halt_exec, core_sleep_exec, em_go} <= 3'h1;
        @(posedge clk_sys);
        em_go <= 1'h0;
        wait_hi(bus_grant);
        check("park", {halt_status, doze_status}, st);
        check("park_quiet", {mem_tran, io_tran, first_cycle_marker}, 3'h0);
        @(posedge clk_sys);
        {int_req, nmi_req, wait_req} <= {hlt, !hlt, 1'h1};
        for (int n = 0; n < 12 && bus_grant === 1'h1; n++)
        begin
            @(posedge clk_sys);
            #1;
            if (bus_grant === 1'h1)
                check("park_hold", {halt_status, doze_status}, st);
        end
        repeat (4) @(posedge clk_sys);
        #1;
        check("wake", {halt_status, doze_status}, 2'h0);
        @(posedge clk_sys);
        {int_req, nmi_req, wait_req} <= 3'h0;
    endtask

    initial
    begin
        clk_sys = 1'h0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial
    begin
        errors = 0;
        cmp_count = 0;
        {rst, user_rst_n, core_instr_end} = 3'h7;
        {wait_req, int_req, nmi_req, em_go, lookahead_en} = 5'h0;
        {core_reti, core_addr_calc, core_halt_exec, core_sleep_exec} = 4'h0;
        {chan_transfer_request, chan_edge_mode, chan_dma_write} = 5'h0;
        {chan_dma_addr, core_addr, core_next_pc} = 48'h0;
        {chan_dma_wdata, core_wdata, mem_data_in} = 24'h0;
        core_kind = K_IDLE;
        repeat (8) @(posedge clk_sys);
        rst <= 1'h0;
        t_cycles();
        t_look();
        t_grant();
        t_park(1'h1);
        t_park(1'h0);
        @(posedge clk_sys);
        user_rst_n <= 1'h0;
        repeat (2) @(posedge clk_sys);
        #1;
        check("ureset", {bus_grant, halt_status, io_addr_out}, 18'h0);
        check("pf_keep", pf_byte, 8'h3E);
        summarize();
    end

    initial
    begin
        #(40 * 3000);
        errors++;
        summarize();
    end
endmodule

bind cbrc_top cbrc_assertions chk_u (.*);
`default_nettype wire
